// File: src/lccr_cfg.svh
// Register map, field positions and reset values of the lane config capture bank.
// Assumes inclusion by bare name from the package and the design files.
`ifndef LCCR_CFG_SVH
`define LCCR_CFG_SVH

// Printed offsets are register indices; byte address is four times the index
`define LCCR_IDX_LANE_INVERT   12'h0334
`define LCCR_IDX_DEVICE_IDENT  12'h0400
`define LCCR_IDX_BANK_IDENT    12'h0401
`define LCCR_IDX_LANE_IDENT    12'h0402
`define LCCR_IDX_SCRAMBLE_L    12'h0403
`define LCCR_IDX_OCTETS_FRAME  12'h0404
`define LCCR_IDX_FRAMES_MF     12'h0405
`define LCCR_IDX_CONVERTERS    12'h0406
`define LCCR_IDX_CS_RES        12'h0407
`define LCCR_IDX_SUBCLASS_NP   12'h0408
// Own capture status register: bit 0 set once any configuration was taken
`define LCCR_IDX_CAPTURE_STAT  12'h0410

// Reset values
`define LCCR_RST_BYTE          8'h00

// Field positions inside the configuration octets
`define LCCR_LID_MSB           4
`define LCCR_PHADJ_BIT         5
`define LCCR_ADJDIR_BIT        6
`define LCCR_SCR_BIT           7
`define LCCR_L_MSB             4
`define LCCR_K_MSB             4
`define LCCR_N_MSB             4
`define LCCR_CS_LSB            6
`define LCCR_NP_MSB            4
`define LCCR_SUBCLASS_LSB      5
`define LCCR_SUBCLASS_MSB      7

// Configuration octet positions in the lane 0 sequence
`define LCCR_CFG_OCTETS        4'h9
`define LCCR_OCT_DID           4'h0
`define LCCR_OCT_BID           4'h1
`define LCCR_OCT_LID           4'h2
`define LCCR_OCT_SCR_L         4'h3
`define LCCR_OCT_F             4'h4
`define LCCR_OCT_K             4'h5
`define LCCR_OCT_M             4'h6
`define LCCR_OCT_CS_N          4'h7
`define LCCR_OCT_NP            4'h8

`endif

// File: src/lccr_pkg.sv
// Types shared by the lane config capture bank modules.
// Assumes the constants header is found on the include path.
`include "lccr_cfg.svh"
package lccr_pkg;
  // Bus address index width (word index)
  typedef logic [11:0] lccr_index_type;
  // One configuration octet
  typedef logic [7:0] lccr_byte_type;
  // Captured configuration bank
  typedef lccr_byte_type [8:0] lccr_bank_type;
endpackage

// File: src/lccr_cap_if.sv
// Interface carrying captured lane 0 configuration from capture to bank.
// Assumes one clock domain, shared by both modules.
`timescale 1ns/10ps
`default_nettype none
interface lccr_cap_if;
  import lccr_pkg::*;
  lccr_bank_type bank;    // Captured octets
  logic          seen;    // Any sequence captured
  modport capture (output bank, output seen);
  modport bank_side (input bank, input seen);
endinterface
`default_nettype wire

// File: src/lccr_ilas_capture.sv
// Capture of the lane 0 link configuration octets during alignment.
// Assumes cfg_valid_i marks configuration octets in order, start first.
`timescale 1ns/10ps
`default_nettype none
`include "lccr_cfg.svh"
module lccr_ilas_capture (
  input  wire logic         clk_i,        // 40 MHz clock
  input  wire logic         rst_i,        // Sync reset, high
  input  wire logic         cfg_start_i,  // First configuration octet
  input  wire logic         cfg_valid_i,  // Octet valid
  input  wire logic [7:0]   cfg_octet_i,  // Octet from lane 0
  lccr_cap_if.capture       cap           // Captured bank out
);
  import lccr_pkg::*;

  logic [3:0]    octet_pos;   // Position within sequence
  lccr_bank_type shadow;      // Octets under assembly

  // Octet position; start octet sets it to the second slot (bank ident)
  // Reset parks it past the end, so stray octets before a start never publish
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      octet_pos <= `LCCR_CFG_OCTETS;
    end else if (cfg_valid_i) begin
      if (cfg_start_i) begin
        octet_pos <= `LCCR_OCT_BID;
      end else if (octet_pos != `LCCR_CFG_OCTETS) begin
        octet_pos <= octet_pos + 4'h1;
      end
    end
  end

  // Assemble; whole set published only when complete, so readers see one set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shadow   <= '0;
      cap.bank <= '0;
      cap.seen <= 1'b0;
    end else if (cfg_valid_i) begin
      if (cfg_start_i) begin
        shadow[`LCCR_OCT_DID] <= cfg_octet_i;
      end else if (octet_pos == `LCCR_OCT_NP) begin
        cap.bank <= shadow;
        cap.bank[`LCCR_OCT_NP] <= cfg_octet_i;
        cap.seen <= 1'b1;
      end else if (octet_pos != `LCCR_CFG_OCTETS) begin
        shadow[octet_pos] <= cfg_octet_i;
      end
    end
  end
endmodule
`default_nettype wire

// File: src/lccr_regs.sv
// What this block does
// - Bit n inverts lane n data
// - Capture device and bank identifiers, read-only
// - Capture lane ident, phase request, direction
// - Scramble flag lands in bit seven
// - Lane count read as lanes minus one
// - Frames per multiframe held minus one
// - Converter count held minus one
// - Control bits field always reads zero
// - Resolution held minus one, five bits
// - Bits per sample held minus one
// - Capture subclass version, read-only
//
// Register bank of the receiver: lane inversion control and the
// captured lane 0 configuration, reached over classic Wishbone.
// Assumes all lane data and the bus share clk_i.
`timescale 1ns/10ps
`default_nettype none
`include "lccr_cfg.svh"
module lccr_regs #(
  parameter int LANES = 8,   // Receive lanes
  parameter int LANE_W = 40  // Deserialized bits per lane
) (
  input  wire logic                   clk_i,         // 40 MHz clock
  input  wire logic                   rst_i,         // Sync reset, high
  // Wishbone slave
  input  wire logic                   wb_cyc_i,      // Cycle
  input  wire logic                   wb_stb_i,      // Strobe
  input  wire logic                   wb_we_i,       // Write enable
  input  wire logic [13:0]            wb_adr_i,      // Byte address
  input  wire logic [3:0]             wb_sel_i,      // Byte lanes
  input  wire logic [31:0]            wb_dat_i,      // Write data
  output logic      [31:0]            wb_dat_o,      // Read data
  output logic                        wb_ack_o,      // Acknowledge
  // Lane 0 configuration octets
  input  wire logic                   cfg_start_i,   // First octet
  input  wire logic                   cfg_valid_i,   // Octet valid
  input  wire logic [7:0]             cfg_octet_i,   // Octet value
  // Lane data path
  input  wire logic [LANES*LANE_W-1:0] lane_data_i,  // Raw deserialized
  output logic      [LANES*LANE_W-1:0] lane_data_o   // After inversion
);
  import lccr_pkg::*;

  lccr_cap_if     cap_bus ();     // Captured configuration
  lccr_byte_type  lane_invert_bits; // Inversion control
  lccr_index_type word_idx;       // Register index
  logic           bus_req;        // Live request
  logic [31:0]    next_rdata;     // Read mux output

  // Capture engine fed from lane 0; the far end must send it there
  lccr_ilas_capture u_capture (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .cfg_start_i (cfg_start_i),
    .cfg_valid_i (cfg_valid_i),
    .cfg_octet_i (cfg_octet_i),
    .cap         (cap_bus.capture)
  );

  assign word_idx = wb_adr_i[13:2];
  // Ack pulse ends a request; ack high blocks a second take
  assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Ack one cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Lane inversion control; only byte lane 0 carries it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lane_invert_bits <= `LCCR_RST_BYTE;
    end else if (bus_req && wb_we_i && wb_sel_i[0] &&
                 word_idx == `LCCR_IDX_LANE_INVERT) begin
      lane_invert_bits <= wb_dat_i[7:0];
    end
  end

  // Per-lane inversion, registered so outputs come from flip-flops
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          lane_data_o[g*LANE_W +: LANE_W] <= '0;
        end else if (lane_invert_bits[g]) begin
          lane_data_o[g*LANE_W +: LANE_W] <= ~lane_data_i[g*LANE_W +: LANE_W];
        end else begin
          lane_data_o[g*LANE_W +: LANE_W] <= lane_data_i[g*LANE_W +: LANE_W];
        end
      end
    end
  endgenerate

  // Read mux; captured fields are read-only, writes to them fall away.
  // Minus-one encodings arrive that way on the link and are kept as sent.
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (word_idx)
      `LCCR_IDX_LANE_INVERT: begin
        next_rdata[7:0] = lane_invert_bits;
      end
      `LCCR_IDX_DEVICE_IDENT: begin
        next_rdata[7:0] = cap_bus.bank[`LCCR_OCT_DID];
      end
      `LCCR_IDX_BANK_IDENT: begin
        next_rdata[7:0] = cap_bus.bank[`LCCR_OCT_BID];
      end
      `LCCR_IDX_LANE_IDENT: begin
        // Ident, phase request and direction; bit 7 reserved
        next_rdata[`LCCR_LID_MSB:0] = cap_bus.bank[`LCCR_OCT_LID][`LCCR_LID_MSB:0];
        next_rdata[`LCCR_PHADJ_BIT] = cap_bus.bank[`LCCR_OCT_LID][`LCCR_PHADJ_BIT];
        next_rdata[`LCCR_ADJDIR_BIT] = cap_bus.bank[`LCCR_OCT_LID][`LCCR_ADJDIR_BIT];
      end
      `LCCR_IDX_SCRAMBLE_L: begin
        next_rdata[`LCCR_SCR_BIT] = cap_bus.bank[`LCCR_OCT_SCR_L][`LCCR_SCR_BIT];
        next_rdata[`LCCR_L_MSB:0] = cap_bus.bank[`LCCR_OCT_SCR_L][`LCCR_L_MSB:0];
      end
      `LCCR_IDX_OCTETS_FRAME: begin
        next_rdata[7:0] = cap_bus.bank[`LCCR_OCT_F];
      end
      `LCCR_IDX_FRAMES_MF: begin
        // Value as sent; only 16 or 32 frames are legal
        next_rdata[`LCCR_K_MSB:0] = cap_bus.bank[`LCCR_OCT_K][`LCCR_K_MSB:0];
      end
      `LCCR_IDX_CONVERTERS: begin
        next_rdata[7:0] = cap_bus.bank[`LCCR_OCT_M];
      end
      `LCCR_IDX_CS_RES: begin
        // Control bits field forced to zero; device takes none
        next_rdata[7:`LCCR_CS_LSB] = 2'b00;
        next_rdata[`LCCR_N_MSB:0] = cap_bus.bank[`LCCR_OCT_CS_N][`LCCR_N_MSB:0];
      end
      `LCCR_IDX_SUBCLASS_NP: begin
        next_rdata[`LCCR_NP_MSB:0] = cap_bus.bank[`LCCR_OCT_NP][`LCCR_NP_MSB:0];
        next_rdata[`LCCR_SUBCLASS_MSB:`LCCR_SUBCLASS_LSB] =
          cap_bus.bank[`LCCR_OCT_NP][`LCCR_SUBCLASS_MSB:`LCCR_SUBCLASS_LSB];
      end
      `LCCR_IDX_CAPTURE_STAT: begin
        next_rdata[0] = cap_bus.seen;
      end
      default: begin
        // Unmapped reads return zero and still ack
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data registered with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req) begin
      wb_dat_o <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// File: sim/lccr_regs_properties.sv
// Checker: bus answer, lane inversion and captured field shape.
// Assumes a bind onto lccr_regs, one clock, sync reset.
`timescale 1ns/10ps
`default_nettype none
`include "lccr_cfg.svh"
module lccr_chk #(
  parameter int LANES  = 8,
  parameter int LANE_W = 40
) (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [13:0]             wb_adr_i,
  input wire logic [3:0]              wb_sel_i,
  input wire logic [31:0]             wb_dat_i,
  input wire logic [31:0]             wb_dat_o,
  input wire logic                    wb_ack_o,
  input wire logic [LANES*LANE_W-1:0] lane_data_i,
  input wire logic [LANES*LANE_W-1:0] lane_data_o
);
  wire logic        take = wb_cyc_i & wb_stb_i & !wb_ack_o;  // Taken now
  wire logic        rd   = wb_ack_o & !wb_we_i;              // Read answered
  wire logic [11:0] ix   = wb_adr_i[13:2];                   // Word index
  wire logic        wr   = take & wb_we_i & wb_sel_i[0] & (ix == `LCCR_IDX_LANE_INVERT);
  logic [7:0]              inv;  // Shadow of inversion control
  logic [LANES*LANE_W-1:0] msk;  // Spread per lane
  // Shadow stores at the take edge, as the bank does
  always_ff @(posedge clk_i) begin
    if (rst_i) inv <= 8'h00;
    else if (wr) inv <= wb_dat_i[7:0];
  end
  always_comb begin
    for (int g = 0; g < LANES; g++) msk[g*LANE_W +: LANE_W] = {LANE_W{inv[g]}};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_one; take |=> wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("no ack after request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_lane; !rst_i |=> lane_data_o == ($past(lane_data_i) ^ $past(msk)); endproperty
  a_lane: assert property (p_lane) else $error("lane inversion wrong");
  property p_inv_rd; rd && ix == `LCCR_IDX_LANE_INVERT |-> wb_dat_o[7:0] == inv; endproperty
  a_inv_rd: assert property (p_inv_rd) else $error("inversion readback wrong");
  property p_rst; disable iff (1'b0)
    rst_i |=> !wb_ack_o && wb_dat_o == 32'h0000_0000 && lane_data_o == '0; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_upper; rd |-> wb_dat_o[31:8] == 24'h00_0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_cs; rd && ix == `LCCR_IDX_CS_RES |-> wb_dat_o[7:5] == 3'h0; endproperty
  a_cs: assert property (p_cs) else $error("control bits not zero");
  property p_k; rd && ix == `LCCR_IDX_FRAMES_MF |-> wb_dat_o[7:5] == 3'h0; endproperty
  a_k: assert property (p_k) else $error("frame count upper bits set");
endmodule
bind lccr_regs lccr_chk #(.LANES(LANES), .LANE_W(LANE_W)) i_lccr_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lane_data_i(lane_data_i),
  .lane_data_o(lane_data_o)
);
`default_nettype wire

// File: sim/lccr_tx_model.sv
// Transmitter model: sends lane 0 configuration octets.
// Assumes send is called just after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module lccr_tx_model (
  input  wire logic       clk_i,        // Shared clock
  output var logic        cfg_start_o,  // First octet
  output var logic        cfg_valid_o,  // Octet strobe
  output var logic  [7:0] cfg_octet_o   // Octet
);
  initial begin
    cfg_start_o = 1'b0;
    cfg_valid_o = 1'b0;
    cfg_octet_o = 8'h00;
  end
  // Idle line shows the inverse so a stale octet never looks valid
  task automatic send(input logic [7:0] oct [9], input int cnt, input int gap);
    for (int i = 0; i < cnt; i++) begin
      @(posedge clk_i);
      cfg_start_o <= (i == 0);
      cfg_valid_o <= 1'b1;
      cfg_octet_o <= oct[i];
      repeat (gap + (i == cnt - 1)) begin
        @(posedge clk_i);
        cfg_start_o <= 1'b0;
        cfg_valid_o <= 1'b0;
        cfg_octet_o <= ~oct[i];
      end
    end
  endtask
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Bench: bus reads and writes, lane data and configuration sets.
// Assumes the transmitter model and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "lccr_cfg.svh"
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [13:0] adr = 14'h0000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] lin = 32'h0000_0000;  // Eight lanes of four bits
  logic [31:0] lout;
  logic [31:0] rdat;
  logic [31:0] r;                    // Last read value
  logic        ack;
  logic        c_st;
  logic        c_vl;
  logic [7:0]  c_oc;
  logic [7:0]  ea [9];               // Expected set
  logic [7:0]  sa [9];               // Sent set
  int          failures = 0;
  int          compares = 0;
  int          cycles = 0;
  always #12.5 clk_i = ~clk_i;
  lccr_regs #(.LANES(8), .LANE_W(4)) i_lccr_regs (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cfg_start_i(c_st),
    .cfg_valid_i(c_vl), .cfg_octet_i(c_oc), .lane_data_i(lin), .lane_data_o(lout));
  lccr_tx_model i_lccr_tx_model (.clk_i(clk_i), .cfg_start_o(c_st), .cfg_valid_o(c_vl),
    .cfg_octet_o(c_oc));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Classic cycle: hold until ack is sampled, release, one idle cycle
  task automatic wb(input logic w, input logic [11:0] ix, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    wdat <= d;
    @(posedge clk_i);
    // Only ack or the bench timeout ends this wait
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_all(input logic [7:0] e [9]);
    for (int i = 0; i < 9; i++) begin
      wb(1'b0, `LCCR_IDX_DEVICE_IDENT + 12'(i), 32'h0000_0000);
      chk(r, {24'h00_0000, e[i]});
    end
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    ea = '{default: 8'h00};
    rd_all(ea);
    wb(1'b0, `LCCR_IDX_CAPTURE_STAT, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    wb(1'b1, `LCCR_IDX_LANE_INVERT, 32'hFFFF_FFA5);
    wb(1'b0, `LCCR_IDX_LANE_INVERT, 32'h0000_0000);
    chk(r, 32'h0000_00A5);
    lin <= 32'h1234_5678;
    repeat (2) @(posedge clk_i);
    chk(lout, 32'hE2C4_5977);
    ea = '{8'h3C, 8'h0A, 8'h73, 8'h83, 8'h01, 8'h1F, 8'h01, 8'h0F, 8'h2F};
    i_lccr_tx_model.send(ea, 9, 0);
    rd_all(ea);
    wb(1'b0, `LCCR_IDX_CAPTURE_STAT, 32'h0000_0000);
    chk(r, 32'h0000_0001);
    wb(1'b1, `LCCR_IDX_DEVICE_IDENT, 32'h0000_00FF);
    wb(1'b0, 12'h03FF, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    sa = '{default: 8'h99};
    i_lccr_tx_model.send(sa, 5, 2);
    rd_all(ea);
    sa = '{8'h11, 8'h22, 8'hD4, 8'h60, 8'h03, 8'hEF, 8'h00, 8'hE7, 8'h07};
    ea = '{8'h11, 8'h22, 8'h54, 8'h00, 8'h03, 8'h0F, 8'h00, 8'h07, 8'h07};
    i_lccr_tx_model.send(sa, 9, 1);
    rd_all(ea);
    // Second reset in mid-run: captures, status and inversion all clear
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    ea = '{default: 8'h00};
    rd_all(ea);
    wb(1'b0, `LCCR_IDX_CAPTURE_STAT, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    wb(1'b0, `LCCR_IDX_LANE_INVERT, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    chk(lout, 32'h1234_5678);
    tally_and_finish();
  end
endmodule
`default_nettype wire
